// *** hdl/prs_pkg.sv ***
// clock ratio strap decode and unlock fallback constants, states and timing
// assumes a single 50 MHz core clock that is also the cpu clock
package prs_pkg;

    // core clock and the half cpu period unit
    localparam int CORE_CLK_PERIOD_NS   = 20;
    localparam int HALF_CPU_PERIOD_NS   = CORE_CLK_PERIOD_NS / 2;
    // bidirectional reset drive length, in half cpu period units
    localparam int BIDIR_DRIVE_UNITS    = 1024;
    localparam int BIDIR_DRIVE_CYCLES   = (BIDIR_DRIVE_UNITS * HALF_CPU_PERIOD_NS
                                           + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int DRIVE_CNT_W          = 10;
    localparam logic [DRIVE_CNT_W-1:0] DRIVE_LAST = DRIVE_CNT_W'(BIDIR_DRIVE_CYCLES - 1);

    // strap codes
    localparam int          STRAP_W     = 3;
    localparam logic [2:0]  STRAP_X4    = 3'h7;
    localparam logic [2:0]  STRAP_X3    = 3'h6;
    localparam logic [2:0]  STRAP_X8    = 3'h5;
    localparam logic [2:0]  STRAP_X5    = 3'h4;
    localparam logic [2:0]  STRAP_BYP   = 3'h3;
    localparam logic [2:0]  STRAP_X10   = 3'h2;
    localparam logic [2:0]  STRAP_HALF  = 3'h1;
    localparam logic [2:0]  STRAP_X16   = 3'h0;

    // divider and multiplier values
    localparam logic [2:0]  PRE_NONE    = 3'h1;
    localparam logic [2:0]  PRE_DIV2    = 3'h2;
    localparam logic [2:0]  PRE_DIV4    = 3'h4;
    localparam logic [6:0]  MUL_NONE    = 7'h01;
    localparam logic [6:0]  MUL_40      = 7'h28;
    localparam logic [6:0]  MUL_48      = 7'h30;
    localparam logic [6:0]  MUL_64      = 7'h40;
    localparam logic [2:0]  VDIV_NONE   = 3'h1;
    localparam logic [2:0]  VDIV_2      = 3'h2;
    localparam logic [2:0]  VDIV_4      = 3'h4;

    // legal operating windows in kHz
    localparam int PLL_IN_MIN_KHZ       = 1000;
    localparam int PLL_IN_MAX_KHZ       = 3500;
    localparam int VCO_MIN_KHZ          = 64000;
    localparam int VCO_MAX_KHZ          = 128000;
    localparam int CPU_MIN_KHZ          = 16000;
    localparam int CPU_MAX_KHZ          = 64000;
    localparam int XTAL_KHZ_DEFAULT     = 8000;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_FREE  = 3'b010,
        ST_DRIVE = 3'b100
    } prs_state_t;

endpackage

// *** hdl/prs_sync_if.sv ***
// carries one raw input group into a synchroniser and its settled copy back
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface prs_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] stable;
    modport user (output raw, input stable);
    modport sync (input raw, output stable);
endinterface
`default_nettype wire

// *** hdl/prs_sync.sv ***
// three-stage synchroniser; a bit changes once stages two and three agree
// assumes the source is asynchronous to core_clk; data flops carry no reset
`timescale 1ns/1ps
`default_nettype none
module prs_sync #(
    parameter int W = 1
) (
    input  wire logic   core_clk,
    prs_sync_if.sync    bus
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] stable_reg;
    logic [W-1:0] s1_next;
    logic [W-1:0] s2_next;
    logic [W-1:0] s3_next;
    logic [W-1:0] stable_next;

    always_comb begin
        s1_next     = bus.raw;
        s2_next     = s1_reg;
        s3_next     = s2_reg;
        // take the settled value where stages agree, hold where they differ
        stable_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stable_reg);
    end

    always_ff @(posedge core_clk) begin
        s1_reg     <= s1_next;
        s2_reg     <= s2_next;
        s3_reg     <= s3_next;
        stable_reg <= stable_next;
    end

    assign bus.stable = stable_reg;
endmodule
`default_nettype wire

// *** hdl/prs_ratio_ctrl.sv ***
// clock ratio strap capture, pll unlock fallback and bidirectional reset drive
// assumes core_clk is the cpu clock; straps, lock and reset pin are asynchronous
`timescale 1ns/1ps
`default_nettype none
module prs_ratio_ctrl
    import prs_pkg::*;
#(
    parameter int XTAL_KHZ = XTAL_KHZ_DEFAULT
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [2:0]  clock_ratio_straps,
    input  wire logic        pll_lock,
    input  wire logic        bidir_reset_req,
    input  wire logic        reset_input_pin_in,
    output logic      [2:0]  in_prescale,
    output logic      [6:0]  vco_mult,
    output logic      [2:0]  vco_div,
    output logic             pll_bypass,
    output logic             out_half,
    output logic             freq_range_err,
    output logic             unlock_irq,
    output logic             ref_connect,
    output logic             reset_input_pin_out,
    output logic             reset_input_pin_oe
);
    prs_sync_if #(.W(STRAP_W)) strap_if ();
    prs_sync_if #(.W(2))       lvl_if ();
    assign strap_if.raw = clock_ratio_straps;
    assign lvl_if.raw   = {reset_input_pin_in, pll_lock};
    prs_sync #(.W(STRAP_W)) u_strap_sync (.core_clk(core_clk), .bus(strap_if));
    prs_sync #(.W(2))       u_lvl_sync   (.core_clk(core_clk), .bus(lvl_if));

    logic       lock_s;
    logic       pin_s;
    assign lock_s = lvl_if.stable[0];
    assign pin_s  = lvl_if.stable[1];

    // strap decode
    logic [2:0] pre_dec;
    logic [6:0] mul_dec;
    logic [2:0] vdiv_dec;
    logic       byp_dec, half_dec, range_bad;
    int         in_khz, vco_khz, cpu_khz;
    always_comb begin
        pre_dec  = PRE_DIV4;
        mul_dec  = MUL_64;
        vdiv_dec = VDIV_2;
        byp_dec  = 1'b0;
        half_dec = 1'b0;
        case (strap_if.stable)
            STRAP_X4: begin
                vdiv_dec = VDIV_4;
            end
            STRAP_X3: begin
                mul_dec  = MUL_48;
                vdiv_dec = VDIV_4;
            end
            STRAP_X8: begin
                mul_dec  = MUL_64;
            end
            STRAP_X5: begin
                mul_dec  = MUL_40;
            end
            STRAP_BYP: begin
                pre_dec  = PRE_NONE;
                mul_dec  = MUL_NONE;
                vdiv_dec = VDIV_NONE;
                byp_dec  = 1'b1;
            end
            STRAP_X10: begin
                pre_dec  = PRE_DIV2;
                mul_dec  = MUL_40;
            end
            STRAP_HALF: begin
                pre_dec  = PRE_NONE;
                mul_dec  = MUL_NONE;
                vdiv_dec = VDIV_NONE;
                byp_dec  = 1'b1;
                half_dec = 1'b1;
            end
            default: begin
                pre_dec  = PRE_DIV2;
            end
        endcase
        in_khz  = XTAL_KHZ / int'(pre_dec);
        vco_khz = in_khz * int'(mul_dec);
        cpu_khz = vco_khz / int'(vdiv_dec);
        // flag an operating point outside the legal windows
        range_bad = !byp_dec &&
                    (in_khz < PLL_IN_MIN_KHZ || in_khz > PLL_IN_MAX_KHZ ||
                     vco_khz < VCO_MIN_KHZ || vco_khz > VCO_MAX_KHZ ||
                     cpu_khz < CPU_MIN_KHZ || cpu_khz > CPU_MAX_KHZ);
    end

    // strap capture
    logic       capture_reg, capture_next;
    logic [2:0] pre_reg, pre_next;
    logic [6:0] mul_reg, mul_next;
    logic [2:0] vdiv_reg, vdiv_next;
    logic       byp_reg, byp_next;
    logic       half_reg, half_next;
    logic       err_reg, err_next;
    always_comb begin
        capture_next = 1'b0;
        pre_next     = pre_reg;
        mul_next     = mul_reg;
        vdiv_next    = vdiv_reg;
        byp_next     = byp_reg;
        half_next    = half_reg;
        err_next     = err_reg;
        // latch once, first edge after reset release
        if (capture_reg) begin
            pre_next  = pre_dec;
            mul_next  = mul_dec;
            vdiv_next = vdiv_dec;
            byp_next  = byp_dec;
            half_next = half_dec;
            err_next  = range_bad;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            capture_reg <= 1'b1;
            pre_reg     <= PRE_NONE;
            mul_reg     <= MUL_NONE;
            vdiv_reg    <= VDIV_NONE;
            byp_reg     <= 1'b1;
            half_reg    <= 1'b0;
            err_reg     <= 1'b0;
        end else begin
            capture_reg <= capture_next;
            pre_reg     <= pre_next;
            mul_reg     <= mul_next;
            vdiv_reg    <= vdiv_next;
            byp_reg     <= byp_next;
            half_reg    <= half_next;
            err_reg     <= err_next;
        end
    end

    // lock supervision
    prs_state_t             state_reg, state_next;
    logic                   ref_reg, ref_next;
    logic                   irq_reg, irq_next;
    logic                   armed_reg, armed_next;
    logic                   oe_reg, oe_next;
    logic [DRIVE_CNT_W-1:0] cnt_reg, cnt_next;
    always_comb begin
        state_next = state_reg;
        ref_next   = ref_reg;
        irq_next   = 1'b0;
        armed_next = armed_reg;
        oe_next    = oe_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ST_RUN: begin
                if (bidir_reset_req) begin
                    state_next = ST_DRIVE;
                    ref_next   = 1'b1;
                    armed_next = 1'b0;
                    oe_next    = 1'b1;
                    cnt_next   = '0;
                end else if (armed_reg && !lock_s && !byp_reg) begin
                    irq_next   = 1'b1;
                    ref_next   = 1'b0;
                    armed_next = 1'b0;
                    state_next = ST_FREE;
                end else if (!pin_s) begin
                    // reset pin low: wait for relock before supervising
                    armed_next = 1'b0;
                end else if (lock_s && !byp_reg && !capture_reg) begin
                    armed_next = 1'b1;
                end
            end
            ST_FREE: begin
                // only a low reset pin, a bidirectional reset request or rst_b low restores the reference
                if (bidir_reset_req) begin
                    state_next = ST_DRIVE;
                    ref_next   = 1'b1;
                    oe_next    = 1'b1;
                    cnt_next   = '0;
                end else if (!pin_s) begin
                    state_next = ST_RUN;
                    ref_next   = 1'b1;
                end
            end
            ST_DRIVE: begin
                // fixed drive length on the reset pin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == DRIVE_LAST) begin
                    oe_next    = 1'b0;
                    cnt_next   = '0;
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
                ref_next   = 1'b1;
                oe_next    = 1'b0;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= ST_RUN;
            ref_reg   <= 1'b1;
            irq_reg   <= 1'b0;
            armed_reg <= 1'b0;
            oe_reg    <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            ref_reg   <= ref_next;
            irq_reg   <= irq_next;
            armed_reg <= armed_next;
            oe_reg    <= oe_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign in_prescale         = pre_reg;
    assign vco_mult            = mul_reg;
    assign vco_div             = vdiv_reg;
    assign pll_bypass          = byp_reg;
    assign out_half            = half_reg;
    assign freq_range_err      = err_reg;
    assign unlock_irq          = irq_reg;
    assign ref_connect         = ref_reg;
    assign reset_input_pin_out = 1'b0;
    assign reset_input_pin_oe  = oe_reg;

    // checks
    int oe_len;
    int chk_in, chk_vco, chk_cpu;
    always_ff @(posedge core_clk) begin
        if (!rst_b || !oe_reg) begin
            oe_len <= 0;
        end else begin
            oe_len <= oe_len + 1;
        end
    end
    always_comb begin
        chk_in  = XTAL_KHZ / int'(pre_reg);
        chk_vco = chk_in * int'(mul_reg);
        chk_cpu = chk_vco / int'(vdiv_reg);
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    strap_hold_a: assert property (!capture_reg |=> $stable(mul_reg) && $stable(vdiv_reg)
        && $stable(pre_reg) && $stable(byp_reg)) else $error("ratio changed after capture");
    // sampled rst_b keeps the release edge itself out of the capture checks
    ratio_three_a: assert property (rst_b && capture_reg && strap_if.stable == STRAP_X3 |=>
        pre_reg == PRE_DIV4 && mul_reg == MUL_48 && vdiv_reg == VDIV_4 && !byp_reg)
        else $error("code 110 not decoded as times three");
    ratio_five_a: assert property (rst_b && capture_reg && strap_if.stable == STRAP_X5 |=>
        pre_reg == PRE_DIV4 && mul_reg == MUL_40 && vdiv_reg == VDIV_2 && !byp_reg)
        else $error("code 100 not decoded as times five");
    bypass_half_a: assert property (rst_b && capture_reg && strap_if.stable == STRAP_HALF
        |=> byp_reg && half_reg ##1 byp_reg && half_reg) else $error("code 001 not bypass halved");
    in_range_a: assert property (!capture_reg && !byp_reg && !err_reg |->
        chk_in >= PLL_IN_MIN_KHZ && chk_in <= PLL_IN_MAX_KHZ &&
        chk_vco >= VCO_MIN_KHZ && chk_vco <= VCO_MAX_KHZ) else $error("pll input or vco out of range");
    cpu_range_a: assert property (!capture_reg && !byp_reg && !err_reg |->
        chk_cpu >= CPU_MIN_KHZ && chk_cpu <= CPU_MAX_KHZ) else $error("cpu clock out of range");
    unlock_irq_a: assert property (state_reg == ST_RUN && armed_reg && !lock_s && !byp_reg
        && !bidir_reset_req |=> irq_reg ##1 !irq_reg) else $error("unlock request missing");
    ref_drop_a: assert property (irq_reg |-> !ref_reg && state_reg == ST_FREE)
        else $error("reference still connected after unlock");
    ref_hold_a: assert property (state_reg == ST_FREE && !bidir_reset_req && pin_s
        |=> !ref_reg) else $error("reference returned without reset");
    drive_len_a: assert property ($fell(oe_reg) |-> oe_len == BIDIR_DRIVE_CYCLES)
        else $error("reset pin drive length wrong");
    unlock_seen_c: cover property (irq_reg);
    drive_done_c: cover property ($fell(oe_reg));
    free_recover_c: cover property (state_reg == ST_FREE ##1 state_reg == ST_RUN);
    cap_three_c: cover property (capture_reg && strap_if.stable == STRAP_X3);
endmodule
`default_nettype wire

// *** bench/prs_osc_pin_model.sv ***
// crystal reference, pll lock behaviour and reset pin network around the block
// assumes core_clk paces the model; pin has a pull-up and an rc stretch
`timescale 1ns/1ps
`default_nettype none
module prs_osc_pin_model #(
    parameter int LOCK_CYC    = 24,
    parameter int STRETCH_CYC = 40
) (
    input  wire logic core_clk,
    input  wire logic xtal_ok,
    input  wire logic ext_pin_low,
    input  wire logic ref_connect,
    input  wire logic reset_input_pin_out,
    input  wire logic reset_input_pin_oe,
    output logic      pll_lock,
    output logic      reset_input_pin_in
);
    int   lock_cnt    = 0;
    int   stretch_cnt = 0;
    logic pin_driven;

    assign pin_driven = reset_input_pin_oe && !reset_input_pin_out;
    always @(posedge core_clk) begin
        if (pin_driven) begin
            stretch_cnt <= STRETCH_CYC;
        end else if (stretch_cnt > 0) begin
            stretch_cnt <= stretch_cnt - 1;
        end
    end
    // pull-up wins unless something holds the pin low
    assign reset_input_pin_in = !(pin_driven || stretch_cnt > 0 || ext_pin_low);
    always @(posedge core_clk) begin
        if (!xtal_ok || !ref_connect) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_CYC) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    assign pll_lock = (lock_cnt == LOCK_CYC);
endmodule
`default_nettype wire

// *** bench/pll_ratio_select_and_unlock_fallback_test.sv ***
// self-checking bench for strap decode, unlock fallback and bidirectional reset drive
// assumes prs_pkg, prs_ratio_ctrl and prs_osc_pin_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module pll_ratio_select_and_unlock_fallback_test;
    import prs_pkg::*;
    typedef struct {int kind; logic [31:0] exp;} prs_note_t;
    localparam int XTAL = XTAL_KHZ_DEFAULT;
    logic        core_clk           = 1'b0;
    logic        rst_b              = 1'b0;
    logic [2:0]  clock_ratio_straps = 3'h7;
    logic        bidir_reset_req    = 1'b0;
    logic        xtal_ok            = 1'b1;
    logic        ext_pin_low        = 1'b0;
    logic        look               = 1'b0;
    logic        oe_prev            = 1'b0;
    logic [31:0] rnd                = 32'h40BF9CAA;
    logic        pll_lock;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;
    logic        unlock_irq;
    logic        ref_connect;
    wire  [15:0] decoded;
    int          mismatches         = 0;
    int          comparisons        = 0;
    int          drive_len          = 0;
    prs_note_t   notes[$];

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    prs_ratio_ctrl #(.XTAL_KHZ(XTAL)) u_prs_ratio_ctrl (
        .core_clk(core_clk), .rst_b(rst_b), .clock_ratio_straps(clock_ratio_straps),
        .pll_lock(pll_lock), .bidir_reset_req(bidir_reset_req),
        .reset_input_pin_in(pin_in), .in_prescale(decoded[15:13]),
        .vco_mult(decoded[12:6]), .vco_div(decoded[5:3]), .pll_bypass(decoded[2]),
        .out_half(decoded[1]), .freq_range_err(decoded[0]), .unlock_irq(unlock_irq),
        .ref_connect(ref_connect), .reset_input_pin_out(pin_out),
        .reset_input_pin_oe(pin_oe));

    prs_osc_pin_model u_prs_osc_pin_model (
        .core_clk(core_clk), .xtal_ok(xtal_ok), .ext_pin_low(ext_pin_low),
        .ref_connect(ref_connect), .reset_input_pin_out(pin_out),
        .reset_input_pin_oe(pin_oe), .pll_lock(pll_lock), .reset_input_pin_in(pin_in));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function automatic logic [31:0] exp_decode(input logic [2:0] s);
        logic [2:0] p;
        logic [6:0] m;
        logic [2:0] d;
        logic       b;
        int         fi;
        int         fv;
        int         fc;
        {p, m, d, b} = {3'h1, 7'h01, 3'h1, 1'b1};
        case (s)
            3'h7: {p, m, d, b} = {3'h4, 7'h40, 3'h4, 1'b0};
            3'h6: {p, m, d, b} = {3'h4, 7'h30, 3'h4, 1'b0};
            3'h5: {p, m, d, b} = {3'h4, 7'h40, 3'h2, 1'b0};
            3'h4: {p, m, d, b} = {3'h4, 7'h28, 3'h2, 1'b0};
            3'h2: {p, m, d, b} = {3'h2, 7'h28, 3'h2, 1'b0};
            3'h0: {p, m, d, b} = {3'h2, 7'h40, 3'h2, 1'b0};
            default: ;
        endcase
        fi = XTAL / int'(p);
        fv = fi * int'(m);
        fc = fv / int'(d);
        return {16'h0, p, m, d, b, s == 3'h1, !b && (fi < PLL_IN_MIN_KHZ
            || fi > PLL_IN_MAX_KHZ || fv < VCO_MIN_KHZ || fv > VCO_MAX_KHZ
            || fc < CPU_MIN_KHZ || fc > CPU_MAX_KHZ)};
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic note(input int kind, input logic [31:0] exp);
        notes.push_back('{kind, exp});
    endtask

    task automatic look_at(input int kind, input logic [31:0] exp);
        note(kind, exp);
        look <= 1'b1;
        @(posedge core_clk);
        look <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic do_reset(input logic [2:0] s);
        rst_b <= 1'b0;
        clock_ratio_straps <= s;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
    endtask

    // which: 0 lock high, 1 irq pulse, 2 pin drive over
    task automatic wait_for(input int which, input int limit);
        int n;
        n = 0;
        while (n < limit && !(which == 0 ? pll_lock === 1'b1 : which == 1 ?
               unlock_irq === 1'b1 : pin_oe === 1'b0)) begin
            @(posedge core_clk);
            n++;
        end
        if (n == limit) begin
            mismatches++;
            $display("MISMATCH wait %0d expected event seen none", which);
        end
    endtask

    task automatic lose_lock();
        note(1, 32'h2);
        xtal_ok <= 1'b0;
        wait_for(1, 20);
        @(posedge core_clk);
    endtask

    // results appear on a look strobe, an irq pulse or the end of a pin drive
    always @(negedge core_clk) begin
        prs_note_t n;
        if (pin_oe === 1'b1) drive_len++;
        if (look || unlock_irq === 1'b1 || (oe_prev && pin_oe !== 1'b1)) begin
            if (notes.size() == 0) begin
                check("pending notes", 32'h1, 32'h0);
            end else begin
                n = notes.pop_front();
                case (n.kind)
                    0: check("ratio decode", n.exp, {16'h0, decoded});
                    1: check("irq and ref", n.exp, {30'h0, unlock_irq, ref_connect});
                    2: check("pin and ref", n.exp, {30'h0, pin_out, ref_connect});
                    default: check("drive length", n.exp, 32'(drive_len));
                endcase
            end
            if (oe_prev && pin_oe !== 1'b1) drive_len = 0;
        end
        oe_prev <= (pin_oe === 1'b1);
    end

    initial begin
        for (int c = 0; c < 8; c++) begin
            do_reset(3'(c));
            repeat (2) @(posedge core_clk);
            look_at(0, exp_decode(3'(c)));
            rnd = xorshift(rnd);
            clock_ratio_straps <= 3'(c) ^ (rnd[2:0] | 3'h1);
            repeat (8) @(posedge core_clk);
            look_at(0, exp_decode(3'(c)));
        end
        $display("test strap_decode done");
        do_reset(STRAP_X3);
        wait_for(0, 200);
        repeat (10) @(posedge core_clk);
        lose_lock();
        repeat (30) @(posedge core_clk);
        xtal_ok <= 1'b1;
        repeat (40) @(posedge core_clk);
        look_at(2, 32'h0);
        $display("test unlock_fallback done");
        bidir_reset_req <= 1'b1;
        @(posedge core_clk);
        bidir_reset_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        look_at(2, 32'h1);
        note(3, 32'(BIDIR_DRIVE_UNITS * HALF_CPU_PERIOD_NS / CORE_CLK_PERIOD_NS));
        wait_for(2, 600);
        repeat (60) @(posedge core_clk);
        wait_for(0, 200);
        $display("test bidir_drive done");
        lose_lock();
        xtal_ok <= 1'b1;
        ext_pin_low <= 1'b1;
        repeat (10) @(posedge core_clk);
        look_at(2, 32'h1);
        ext_pin_low <= 1'b0;
        repeat (60) @(posedge core_clk);
        lose_lock();
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        look_at(2, 32'h1);
        xtal_ok <= 1'b1;
        do_reset(STRAP_X5);
        repeat (5) @(posedge core_clk);
        $display("test reconnect done");
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        $display("MISMATCH watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
`default_nettype wire
